// ===== dss_sequencer.sv
// Drive sequencing state machine top with status word and ramp controls
`timescale 1ns/1ps
// What this block does
// - State reported as value 0 to 7 in defined order.
// - Starts not ready, moves to switch-on disabled when init done.
// - Shutdown from switch-on disabled or switched on goes to ready.
// - Switch-on while ready goes to switched on.
// - Run forward, reverse or jog while switched on enables operation.
// - Stop in operation returns to switched on after stop completes.
// - Shutdown in operation goes to ready after shutdown completes.
// - Quick stop or voltage off from ready/switched on, voltage off from run: disabled.
// - Quick stop in operation enters quick stop active.
// - Quick stop left when it completes or on voltage off.
// - Trip enters fault reaction; completion or voltage off gives faulted.
// - Fault reset edge in faulted goes to disabled if fault cleared.
// - Active command word copied from network, application or keypad.
// - Bits 4, 5, 6 clear zero ramp output, hold ramp, zero input.
// - Only a rising edge of bit 7 resets faults.
// - Bit 12 set allows disabled to ready regardless of bit 0.
// - Bits 14 and 15 select remote sequencing and reference.
// - Status bits 0 to 6 flag the sequencer conditions.
// - Status bits 8, 9, 13, 14, 15 flag net, jog, reverse, stopping.
// - Status word readable whatever the command source.
// - Ramp active only in operation enabled.
module dss_sequencer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command word sources
  input  wire logic [1:0]  src_sel,
  input  wire logic [15:0] net_word,
  input  wire logic [15:0] app_word,
  input  wire logic [15:0] keypad_panel_word,
  // Internal events
  input  wire logic        init_done,
  input  wire logic        stop_done,
  input  wire logic        shutdown_done,
  input  wire logic        quick_stop_done,
  input  wire logic        fault_reaction_done,
  input  wire logic        trip,
  input  wire logic        fault_present,
  // Registers
  output logic [7:0]       sequencing_state_value,
  output logic [15:0]      active_command_word,
  output logic [15:0]      sequencer_status_word,
  // Ramp and remote control
  output logic             ramp_active,
  output logic             ramp_out_zero,
  output logic             ramp_hold,
  output logic             ramp_in_zero,
  output logic             remote_sequencing,
  output logic             remote_reference
);

  dss_cmd_if cmd ();

  dss_cmd_decode u_dec (
    .clk               (clk),
    .rst               (rst),
    .src_sel           (src_sel),
    .net_word          (net_word),
    .app_word          (app_word),
    .keypad_panel_word (keypad_panel_word),
    .cmd               (cmd)
  );

  dss_pkg::dss_state_e state_q;
  dss_pkg::dss_state_e state_d;
  logic [15:0]         status_q;
  logic [15:0]         status_d;
  logic [15:0]         w;
  logic                run_fwd;
  logic                run_jog;
  logic                run_rev;
  logic                any_run;
  logic                in_op;

  assign w       = cmd.word;
  assign run_fwd = w[dss_pkg::CW_RUN_FWD];
  assign run_jog = w[dss_pkg::CW_JOG];
  assign run_rev = w[dss_pkg::CW_RUN_REV];
  assign any_run = run_fwd || run_jog || run_rev;
  assign in_op   = (state_q == dss_pkg::DSS_OP_ENABLED);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dss_pkg::DSS_NOT_READY:
        if (init_done)
          state_d = dss_pkg::DSS_SWITCH_ON_DISABLED;
      dss_pkg::DSS_SWITCH_ON_DISABLED:
        if (cmd.shutdown)
          state_d = dss_pkg::DSS_READY;
      dss_pkg::DSS_READY:
        if (cmd.disable_voltage || cmd.quick_stop)
          state_d = dss_pkg::DSS_SWITCH_ON_DISABLED;
        else if (cmd.switch_on)
          state_d = dss_pkg::DSS_SWITCHED_ON;
      dss_pkg::DSS_SWITCHED_ON:
        if (cmd.disable_voltage || cmd.quick_stop)
          state_d = dss_pkg::DSS_SWITCH_ON_DISABLED;
        else if (cmd.shutdown)
          state_d = dss_pkg::DSS_READY;
        else if (cmd.enable_op)
          state_d = dss_pkg::DSS_OP_ENABLED;
      dss_pkg::DSS_OP_ENABLED:
        if (cmd.disable_voltage)
          state_d = dss_pkg::DSS_SWITCH_ON_DISABLED;
        else if (cmd.quick_stop)
          state_d = dss_pkg::DSS_QUICK_STOP;
        else if (cmd.shutdown && shutdown_done)
          state_d = dss_pkg::DSS_READY;
        else if (cmd.switch_on && !any_run && stop_done)
          state_d = dss_pkg::DSS_SWITCHED_ON;
      dss_pkg::DSS_QUICK_STOP:
        if (quick_stop_done || cmd.disable_voltage)
          state_d = dss_pkg::DSS_SWITCH_ON_DISABLED;
      dss_pkg::DSS_FAULT_REACTION:
        if (fault_reaction_done || cmd.disable_voltage)
          state_d = dss_pkg::DSS_FAULTED;
      dss_pkg::DSS_FAULTED:
        if (cmd.fault_reset && !fault_present)
          state_d = dss_pkg::DSS_SWITCH_ON_DISABLED;
      default:
        state_d = dss_pkg::DSS_NOT_READY;
    endcase
    // Trip overrides everything, except re-entry while already reacting or faulted
    if (trip && state_q != dss_pkg::DSS_FAULT_REACTION && state_q != dss_pkg::DSS_FAULTED)
      state_d = dss_pkg::DSS_FAULT_REACTION;
  end

  // Status built from the next state so word and state change together
  always_comb
  begin
    status_d = dss_pkg::SW_RESET;
    status_d[dss_pkg::SW_READY]        = state_d == dss_pkg::DSS_READY ||
                                         state_d == dss_pkg::DSS_SWITCHED_ON ||
                                         state_d == dss_pkg::DSS_OP_ENABLED ||
                                         state_d == dss_pkg::DSS_QUICK_STOP;
    status_d[dss_pkg::SW_SWITCHED_ON]  = state_d == dss_pkg::DSS_SWITCHED_ON ||
                                         state_d == dss_pkg::DSS_OP_ENABLED ||
                                         state_d == dss_pkg::DSS_QUICK_STOP;
    status_d[dss_pkg::SW_OP_ENABLED]   = state_d == dss_pkg::DSS_OP_ENABLED ||
                                         state_d == dss_pkg::DSS_QUICK_STOP;
    status_d[dss_pkg::SW_FAULTED]      = state_d == dss_pkg::DSS_FAULT_REACTION ||
                                         state_d == dss_pkg::DSS_FAULTED;
    status_d[dss_pkg::SW_VOLT_EN]      = w[dss_pkg::CW_COAST_N];
    status_d[dss_pkg::SW_QSTOP_DIS]    = state_d != dss_pkg::DSS_QUICK_STOP;
    status_d[dss_pkg::SW_SON_DISABLED] = state_d == dss_pkg::DSS_SWITCH_ON_DISABLED;
    status_d[dss_pkg::SW_REF_FROM_NET] = w[dss_pkg::CW_REMOTE_REF];
    status_d[dss_pkg::SW_CTL_FROM_NET] = w[dss_pkg::CW_REMOTE_SEQ];
    status_d[dss_pkg::SW_JOGGING]      = state_d == dss_pkg::DSS_OP_ENABLED && run_jog &&
                                         !run_fwd && !run_rev;
    status_d[dss_pkg::SW_REVERSE]      = state_d == dss_pkg::DSS_OP_ENABLED && run_rev;
    status_d[dss_pkg::SW_STOPPING]     = state_d == dss_pkg::DSS_OP_ENABLED && !any_run;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q  <= dss_pkg::DSS_NOT_READY;
      status_q <= dss_pkg::SW_RESET;
    end
    else
    begin
      state_q  <= state_d;
      status_q <= status_d;
    end
  end

  assign sequencing_state_value = {5'h00, state_q};
  assign sequencer_status_word  = status_q;
  assign active_command_word    = w;
  // Ramp controls are level decodes; bits 9 to 11 are never looked at
  assign ramp_active       = in_op;
  assign ramp_out_zero     = !in_op || !w[dss_pkg::CW_RAMP_OUT_EN];
  assign ramp_hold         = in_op && !w[dss_pkg::CW_RAMP_EN];
  assign ramp_in_zero      = !in_op || !w[dss_pkg::CW_RAMP_IN_EN];
  assign remote_sequencing = w[dss_pkg::CW_REMOTE_SEQ];
  assign remote_reference  = w[dss_pkg::CW_REMOTE_REF];

  a_state_range: assert property (@(posedge clk) disable iff (rst)
    sequencing_state_value <= 8'h07)
    else $error("state value out of range");

  a_init_leave: assert property (@(posedge clk) disable iff (rst)
    (state_q == dss_pkg::DSS_NOT_READY && init_done && !trip)
    |=> state_q == dss_pkg::DSS_SWITCH_ON_DISABLED)
    else $error("not ready did not leave on init done");

  a_switch_on_go: assert property (@(posedge clk) disable iff (rst)
    (state_q == dss_pkg::DSS_READY && cmd.switch_on && !trip)
    |=> state_q == dss_pkg::DSS_SWITCHED_ON)
    else $error("switch on not taken");

  a_stop_wait: assert property (@(posedge clk) disable iff (rst)
    (in_op && !stop_done && !shutdown_done && !cmd.disable_voltage && !cmd.quick_stop
     && !trip) |=> state_q == dss_pkg::DSS_OP_ENABLED)
    else $error("left operation before stop completed");

  a_quick_stop_in: assert property (@(posedge clk) disable iff (rst)
    (in_op && cmd.quick_stop && !trip) |=> state_q == dss_pkg::DSS_QUICK_STOP)
    else $error("quick stop not entered");

  a_quick_stop_out: assert property (@(posedge clk) disable iff (rst)
    (state_q == dss_pkg::DSS_QUICK_STOP && quick_stop_done && !trip)
    |=> state_q == dss_pkg::DSS_SWITCH_ON_DISABLED)
    else $error("quick stop exit wrong");

  a_trip_react: assert property (@(posedge clk) disable iff (rst)
    (trip && state_q != dss_pkg::DSS_FAULTED) |=> state_q == dss_pkg::DSS_FAULT_REACTION
    || state_q == dss_pkg::DSS_FAULTED)
    else $error("trip not reacted");

  a_fault_hold: assert property (@(posedge clk) disable iff (rst)
    (state_q == dss_pkg::DSS_FAULTED && fault_present) |=> state_q == dss_pkg::DSS_FAULTED)
    else $error("faulted left while fault present");

  a_status_state: assert property (@(posedge clk) disable iff (rst)
    sequencer_status_word[dss_pkg::SW_SON_DISABLED] ==
    (state_q == dss_pkg::DSS_SWITCH_ON_DISABLED))
    else $error("status disabled bit disagrees with state");

  a_status_zeros: assert property (@(posedge clk) disable iff (rst)
    sequencer_status_word[7] == 1'b0 && sequencer_status_word[12:10] == 3'h0)
    else $error("unused status bits not zero");

  a_ramp_only_op: assert property (@(posedge clk) disable iff (rst)
    ramp_active |-> sequencing_state_value == 8'h04)
    else $error("ramp active outside operation");

endmodule

// ===== dss_pkg.sv
// Package with states, control and status bit positions for the drive sequencer
package dss_pkg;

  typedef enum logic [2:0] {
    DSS_NOT_READY,
    DSS_SWITCH_ON_DISABLED,
    DSS_READY,
    DSS_SWITCHED_ON,
    DSS_OP_ENABLED,
    DSS_QUICK_STOP,
    DSS_FAULT_REACTION,
    DSS_FAULTED
  } dss_state_e;

  // Command word source select
  localparam logic [1:0] SRC_NETWORK = 2'h0;
  localparam logic [1:0] SRC_APP     = 2'h1;
  localparam logic [1:0] SRC_KEYPAD  = 2'h2;

  // Control word bit positions
  localparam int CW_SWITCH_ON     = 0;
  localparam int CW_COAST_N       = 1;
  localparam int CW_ESTOP_N       = 2;
  localparam int CW_RUN_FWD       = 3;
  localparam int CW_RAMP_OUT_EN   = 4;
  localparam int CW_RAMP_EN       = 5;
  localparam int CW_RAMP_IN_EN    = 6;
  localparam int CW_FAULT_RESET   = 7;
  localparam int CW_JOG           = 8;
  localparam int CW_AUTO_INIT     = 12;
  localparam int CW_RUN_REV       = 13;
  localparam int CW_REMOTE_SEQ    = 14;
  localparam int CW_REMOTE_REF    = 15;

  // Status word bit positions
  localparam int SW_READY         = 0;
  localparam int SW_SWITCHED_ON   = 1;
  localparam int SW_OP_ENABLED    = 2;
  localparam int SW_FAULTED       = 3;
  localparam int SW_VOLT_EN       = 4;
  localparam int SW_QSTOP_DIS     = 5;
  localparam int SW_SON_DISABLED  = 6;
  localparam int SW_REF_FROM_NET  = 8;
  localparam int SW_CTL_FROM_NET  = 9;
  localparam int SW_JOGGING       = 13;
  localparam int SW_REVERSE       = 14;
  localparam int SW_STOPPING      = 15;

  // Reset values
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [15:0] SW_RESET = 16'h0000;

endpackage

// ===== dss_cmd_if.sv
// Interface carrying decoded commands from the command decoder to the sequencer
`timescale 1ns/1ps
interface dss_cmd_if;
  logic        shutdown;
  logic        switch_on;
  logic        enable_op;
  logic        disable_voltage;
  logic        quick_stop;
  logic        fault_reset;
  logic [15:0] word;

  modport dec (output shutdown, switch_on, enable_op, disable_voltage, quick_stop,
               fault_reset, word);
  modport seq (input shutdown, switch_on, enable_op, disable_voltage, quick_stop,
               fault_reset, word);
endinterface

// ===== dss_cmd_decode.sv
// Command word source selection, copy and command decode
`timescale 1ns/1ps
module dss_cmd_decode (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command word sources
  input  wire logic [1:0]  src_sel,
  input  wire logic [15:0] net_word,
  input  wire logic [15:0] app_word,
  input  wire logic [15:0] keypad_panel_word,
  // Decoded commands
  dss_cmd_if.dec           cmd
);

  logic [15:0] word_q;
  logic        reset_bit_q;
  logic [15:0] sel_word;

  // Unknown select falls back to keypad, the safe local source
  assign sel_word = (src_sel == dss_pkg::SRC_NETWORK) ? net_word :
                    (src_sel == dss_pkg::SRC_APP)     ? app_word : keypad_panel_word;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      word_q      <= dss_pkg::CW_RESET;
      reset_bit_q <= 1'b0;
    end
    else
    begin
      word_q      <= sel_word;
      reset_bit_q <= word_q[dss_pkg::CW_FAULT_RESET];
    end
  end

  wire switch_on_request = word_q[dss_pkg::CW_SWITCH_ON];
  wire coast_stop_n      = word_q[dss_pkg::CW_COAST_N];
  wire emergency_stop_n  = word_q[dss_pkg::CW_ESTOP_N];
  wire reverse_run_request = word_q[dss_pkg::CW_RUN_REV];

  assign cmd.word            = word_q;
  assign cmd.disable_voltage = !coast_stop_n;
  assign cmd.quick_stop      = coast_stop_n && !emergency_stop_n;
  // Shutdown: voltage and quick stop released, switch-on clear or auto-init
  assign cmd.shutdown        = coast_stop_n && emergency_stop_n &&
                               (!switch_on_request || word_q[dss_pkg::CW_AUTO_INIT]);
  assign cmd.switch_on       = coast_stop_n && emergency_stop_n && switch_on_request;
  assign cmd.enable_op       = cmd.switch_on && (word_q[dss_pkg::CW_RUN_FWD] ||
                               word_q[dss_pkg::CW_JOG] || reverse_run_request);
  // Edge only, a held bit must not clear trips
  assign cmd.fault_reset     = word_q[dss_pkg::CW_FAULT_RESET] && !reset_bit_q;

  a_reset_edge_only: assert property (@(posedge clk) disable iff (rst)
    cmd.fault_reset |=> !cmd.fault_reset)
    else $error("fault reset pulse longer than one cycle");

  a_word_copy_lag: assert property (@(posedge clk) disable iff (rst)
    !$rose(rst) |=> cmd.word == $past(sel_word))
    else $error("active command word not copied from selected source");

endmodule

// ===== dss_plc_model.sv
// Controller model that writes command words into the selected source
`timescale 1ns/1ps
module dss_plc_model (
  // Clock
  input  wire logic        clk,
  // Command word sources
  output logic [1:0]       src_sel,
  output logic [15:0]      net_word,
  output logic [15:0]      app_word,
  output logic [15:0]      keypad_panel_word
);
  initial
  begin
    src_sel           = dss_pkg::SRC_NETWORK;
    net_word          = 16'h0000;
    app_word          = 16'hffff;
    keypad_panel_word = 16'hffff;
  end

  // Unselected sources carry the inverse, so a wrong pick changes the state
  task automatic send(input logic [1:0] src, input logic [15:0] w);
    @(posedge clk);
    src_sel           <= src;
    net_word          <= (src == dss_pkg::SRC_NETWORK) ? w : ~w;
    app_word          <= (src == dss_pkg::SRC_APP) ? w : ~w;
    keypad_panel_word <= (src == dss_pkg::SRC_KEYPAD) ? w : ~w;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking testbench for the drive sequencer
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, init_done, stop_done, shutdown_done;
  logic        quick_stop_done, fault_reaction_done, trip, fault_present;
  logic [1:0]  src_sel;
  logic [15:0] net_word, app_word, keypad_panel_word;
  logic [7:0]  state;
  logic [15:0] act_word, status;
  logic        r_act, r_oz, r_hold, r_iz, r_seq, r_ref;
  int          fails;
  int          check_count;

  dss_plc_model plc (.clk(clk), .src_sel(src_sel), .net_word(net_word),
    .app_word(app_word), .keypad_panel_word(keypad_panel_word));

  dss_sequencer dut (.clk(clk), .rst(rst), .src_sel(src_sel), .net_word(net_word),
    .app_word(app_word), .keypad_panel_word(keypad_panel_word), .init_done(init_done),
    .stop_done(stop_done), .shutdown_done(shutdown_done), .quick_stop_done(quick_stop_done),
    .fault_reaction_done(fault_reaction_done), .trip(trip), .fault_present(fault_present),
    .sequencing_state_value(state), .active_command_word(act_word),
    .sequencer_status_word(status), .ramp_active(r_act), .ramp_out_zero(r_oz),
    .ramp_hold(r_hold), .ramp_in_zero(r_iz), .remote_sequencing(r_seq),
    .remote_reference(r_ref));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [15:0] sw_exp(input logic [2:0] v, input logic [15:0] w);
    logic [15:0] e;
    e = 16'h0000;
    e[0] = (v >= 3'h2) && (v <= 3'h5);
    e[1] = (v >= 3'h3) && (v <= 3'h5);
    e[2] = (v == 3'h4) || (v == 3'h5);
    e[3] = (v >= 3'h6);
    e[4] = w[1];
    e[5] = (v != 3'h5);
    e[6] = (v == 3'h1);
    return e;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Word reaches the state two edges after it is driven
  task automatic expect_st(input logic [2:0] v, input logic [15:0] w);
    chk("state", {13'h0000, v}, {8'h00, state});
    chk("status", sw_exp(v, w), status & 16'h1cff);
  endtask

  task automatic go(input logic [1:0] s, input logic [15:0] w, input logic [2:0] v);
    plc.send(s, w);
    tick(2);
    expect_st(v, w);
  endtask

  task automatic reach_op(input logic [1:0] s, input logic [15:0] run);
    go(s, 16'h0006, 3'h2);
    go(s, 16'h0007, 3'h3);
    go(s, 16'h0007 | run, 3'h4);
    chk("active_word", 16'h0007 | run, act_word);
  endtask

  task automatic t_init;
    tick(2);
    chk("state", 16'h0000, {8'h00, state});
    chk("ramp_active", 16'h0000, {15'h0000, r_act});
    @(posedge clk);
    init_done <= 1'b1;
    tick(2);
    expect_st(3'h1, 16'h0000);
    $display("test init done");
  endtask

  task automatic t_stop;
    reach_op(dss_pkg::SRC_NETWORK, 16'h0008);
    chk("ramp_active", 16'h0001, {15'h0000, r_act});
    go(dss_pkg::SRC_NETWORK, 16'h0007, 3'h4);
    chk("stopping", 16'h0001, {15'h0000, status[15]});
    @(posedge clk);
    stop_done <= 1'b1;
    tick(2);
    expect_st(3'h3, 16'h0007);
    stop_done <= 1'b0;
    go(dss_pkg::SRC_NETWORK, 16'h0006, 3'h2);
    go(dss_pkg::SRC_NETWORK, 16'h0002, 3'h1);
    $display("test stop done");
  endtask

  task automatic t_sources;
    logic [15:0] run [3];
    run = '{16'h0008, 16'h0100, 16'h2000};
    for (int i = 0; i < 3; i++)
    begin
      reach_op(i[1:0], run[i] | (i == 1 ? 16'h0e00 : 16'h0000));
      chk("jog_rev_status", {14'h0000, i == 2, i == 1}, {14'h0000, status[14:13]});
      go(i[1:0], 16'h0006, 3'h4);
      @(posedge clk);
      shutdown_done <= 1'b1;
      tick(2);
      expect_st(3'h2, 16'h0006);
      shutdown_done <= 1'b0;
      go(i[1:0], 16'h0000, 3'h1);
    end
    $display("test sources done");
  endtask

  task automatic t_quick;
    reach_op(dss_pkg::SRC_NETWORK, 16'h0008);
    go(dss_pkg::SRC_NETWORK, 16'h0003, 3'h5);
    @(posedge clk);
    quick_stop_done <= 1'b1;
    tick(2);
    expect_st(3'h1, 16'h0003);
    quick_stop_done <= 1'b0;
    reach_op(dss_pkg::SRC_NETWORK, 16'h0008);
    go(dss_pkg::SRC_NETWORK, 16'h0003, 3'h5);
    go(dss_pkg::SRC_NETWORK, 16'h0001, 3'h1);
    reach_op(dss_pkg::SRC_NETWORK, 16'h0008);
    go(dss_pkg::SRC_NETWORK, 16'h0000, 3'h1);
    go(dss_pkg::SRC_NETWORK, 16'h0006, 3'h2);
    go(dss_pkg::SRC_NETWORK, 16'h0007, 3'h3);
    go(dss_pkg::SRC_NETWORK, 16'h0003, 3'h1);
    $display("test quick stop done");
  endtask

  task automatic t_fault;
    reach_op(dss_pkg::SRC_NETWORK, 16'h0008);
    @(posedge clk);
    trip          <= 1'b1;
    fault_present <= 1'b1;
    tick(2);
    trip <= 1'b0;
    expect_st(3'h6, 16'h000f);
    @(posedge clk);
    fault_reaction_done <= 1'b1;
    tick(2);
    expect_st(3'h7, 16'h000f);
    fault_reaction_done <= 1'b0;
    go(dss_pkg::SRC_NETWORK, 16'h0006, 3'h7);
    go(dss_pkg::SRC_NETWORK, 16'h0086, 3'h7);
    fault_present <= 1'b0;
    tick(3);
    expect_st(3'h7, 16'h0086);
    go(dss_pkg::SRC_NETWORK, 16'h0006, 3'h7);
    go(dss_pkg::SRC_NETWORK, 16'h0086, 3'h1);
    @(posedge clk);
    trip <= 1'b1;
    tick(2);
    trip <= 1'b0;
    expect_st(3'h6, 16'h0086);
    go(dss_pkg::SRC_NETWORK, 16'h0000, 3'h7);
    go(dss_pkg::SRC_NETWORK, 16'h0080, 3'h1);
    $display("test fault done");
  endtask

  task automatic t_ramp;
    go(dss_pkg::SRC_NETWORK, 16'h1007, 3'h2);
    go(dss_pkg::SRC_NETWORK, 16'h0007, 3'h3);
    go(dss_pkg::SRC_NETWORK, 16'h000f, 3'h4);
    chk("ramp_zero_flags", 16'h0007, {13'h0000, r_oz, r_hold, r_iz});
    go(dss_pkg::SRC_NETWORK, 16'hc07f, 3'h4);
    chk("ramp_zero_flags", 16'h0000, {13'h0000, r_oz, r_hold, r_iz});
    chk("remote_flags", 16'h0003, {14'h0000, r_seq, r_ref});
    chk("net_status", 16'h0003, {14'h0000, status[9:8]});
    go(dss_pkg::SRC_NETWORK, 16'h0000, 3'h1);
    chk("ramp_active", 16'h0000, {15'h0000, r_act});
    chk("remote_flags", 16'h0000, {14'h0000, r_seq, r_ref});
    $display("test ramp done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    fails               = 0;
    check_count         = 0;
    rst                 = 1'b1;
    init_done           = 1'b0;
    stop_done           = 1'b0;
    shutdown_done       = 1'b0;
    quick_stop_done     = 1'b0;
    fault_reaction_done = 1'b0;
    trip                = 1'b0;
    fault_present       = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_init;
    t_stop;
    t_sources;
    t_quick;
    t_fault;
    t_ramp;
    complete_run;
  end

  // Whole run is under two hundred cycles
  initial
  begin
    #40000;
    fails++;
    complete_run;
  end
endmodule
